//--- pcwin_pkg.sv
// Constants for the PC Card I/O window configuration block
package pcwin_pkg;
    // Register offsets, compatibility space
    localparam logic [7:0] OFS_ENABLE = 8'h06;
    localparam logic [7:0] OFS_CTRL = 8'h07;
    localparam logic [7:0] OFS_W0_SLO = 8'h08;
    localparam logic [7:0] OFS_W0_SHI = 8'h09;
    localparam logic [7:0] OFS_W0_ELO = 8'h0a;
    localparam logic [7:0] OFS_W0_EHI = 8'h0b;
    localparam logic [7:0] OFS_W1_SLO = 8'h0c;
    localparam logic [7:0] OFS_W1_SHI = 8'h0d;
    localparam logic [7:0] OFS_W1_ELO = 8'h0e;
    localparam logic [7:0] OFS_W1_EHI = 8'h0f;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Enable register: bit 5 reserved, reads zero
    localparam logic [7:0] ENABLE_WMASK = 8'hdf;
    localparam int BIT_IO_WIN1_EN = 7;
    localparam int BIT_IO_WIN0_EN = 6;
    // Control fields, window n at base 4*n
    localparam int BIT_WIDTH_SELECT = 0;
    localparam int BIT_WIDTH_FROM_CARD = 1;
    localparam int BIT_NARROW_FAST = 2;
    localparam int BIT_WIDE_EXTRA_WAIT = 3;
    localparam int WIN1_BASE = 4;
    // Emulated ISA bus timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int ISA_CYCLE_NS = 125;
    localparam int ISA_DIV = (ISA_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] ISA_DIV_LAST = 3'(ISA_DIV - 1);
    // Cycle lengths in ISA cycles
    localparam logic [3:0] LEN_STD8 = 4'h6;
    localparam logic [3:0] LEN_FAST8 = 4'h3;
    localparam logic [3:0] LEN_STD16 = 4'h3;
    localparam logic [3:0] LEN_WAIT16 = 4'h4;
    typedef enum logic {ST_IDLE, ST_RUN} pcwin_state_t;
endpackage

//--- pcwin_match.sv
// Address comparator for one I/O window
`timescale 1ns/10ps
`default_nettype none
module pcwin_match (
    // Window setup
    input wire logic enable,
    input wire logic [15:0] start_addr,
    input wire logic [15:0] end_addr,
    // Host address
    input wire logic [15:0] addr,
    output logic hit
);
    // Inclusive bounds; an inverted range simply never hits
    assign hit = enable && (addr >= start_addr) && (addr <= end_addr);
endmodule // pcwin_match
`default_nettype wire

//--- pcwin_cfg.sv
// I/O window registers, window decode and card cycle timing
`timescale 1ns/10ps
`default_nettype none
module pcwin_cfg (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Host I/O request
    input wire logic io_req,
    input wire logic [15:0] io_addr,
    output logic io_claim,
    output logic io_win,
    output logic io_wide,
    output logic [3:0] io_len,
    output logic io_busy,
    output logic io_done,
    // Card pin
    input wire logic card_iois16
);
    ////////////////////////////////////////////////////////////////////////////
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] enable_reg;
    logic [7:0] ctrl;
    logic [15:0] win0_start;
    logic [15:0] win0_end;
    logic [15:0] win1_start;
    logic [15:0] win1_end;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_reg <= pcwin_pkg::REG_RESET;
            ctrl <= pcwin_pkg::REG_RESET;
            win0_start <= {pcwin_pkg::REG_RESET, pcwin_pkg::REG_RESET};
            win0_end <= {pcwin_pkg::REG_RESET, pcwin_pkg::REG_RESET};
            win1_start <= {pcwin_pkg::REG_RESET, pcwin_pkg::REG_RESET};
            win1_end <= {pcwin_pkg::REG_RESET, pcwin_pkg::REG_RESET};
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                pcwin_pkg::OFS_ENABLE: enable_reg <= reg_wdata & pcwin_pkg::ENABLE_WMASK;
                pcwin_pkg::OFS_CTRL: ctrl <= reg_wdata;
                pcwin_pkg::OFS_W0_SLO: win0_start[7:0] <= reg_wdata;
                pcwin_pkg::OFS_W0_SHI: win0_start[15:8] <= reg_wdata;
                pcwin_pkg::OFS_W0_ELO: win0_end[7:0] <= reg_wdata;
                pcwin_pkg::OFS_W0_EHI: win0_end[15:8] <= reg_wdata;
                pcwin_pkg::OFS_W1_SLO: win1_start[7:0] <= reg_wdata;
                pcwin_pkg::OFS_W1_SHI: win1_start[15:8] <= reg_wdata;
                pcwin_pkg::OFS_W1_ELO: win1_end[7:0] <= reg_wdata;
                pcwin_pkg::OFS_W1_EHI: win1_end[15:8] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Unmapped offsets read zero
    wire [7:0] read_mux =
        (reg_addr == pcwin_pkg::OFS_ENABLE) ? enable_reg :
        (reg_addr == pcwin_pkg::OFS_CTRL) ? ctrl :
        (reg_addr == pcwin_pkg::OFS_W0_SLO) ? win0_start[7:0] :
        (reg_addr == pcwin_pkg::OFS_W0_SHI) ? win0_start[15:8] :
        (reg_addr == pcwin_pkg::OFS_W0_ELO) ? win0_end[7:0] :
        (reg_addr == pcwin_pkg::OFS_W0_EHI) ? win0_end[15:8] :
        (reg_addr == pcwin_pkg::OFS_W1_SLO) ? win1_start[7:0] :
        (reg_addr == pcwin_pkg::OFS_W1_SHI) ? win1_start[15:8] :
        (reg_addr == pcwin_pkg::OFS_W1_ELO) ? win1_end[7:0] :
        (reg_addr == pcwin_pkg::OFS_W1_EHI) ? win1_end[15:8] : 8'h00;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= read_mux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Card IOIS16 pin, three stages, change taken when stages two and three agree
    logic iois_s1;
    logic iois_s2;
    logic iois_s3;
    logic card_wide;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iois_s1 <= 1'b0;
            iois_s2 <= 1'b0;
            iois_s3 <= 1'b0;
            card_wide <= 1'b0;
        end
        else
        begin
            iois_s1 <= card_iois16;
            iois_s2 <= iois_s1;
            iois_s3 <= iois_s2;
            if (iois_s2 == iois_s3)
                card_wide <= iois_s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Window decode
    wire hit0;
    wire hit1;
    pcwin_match u_match0 (
        .enable(enable_reg[pcwin_pkg::BIT_IO_WIN0_EN]),
        .start_addr(win0_start),
        .end_addr(win0_end),
        .addr(io_addr),
        .hit(hit0)
    );
    pcwin_match u_match1 (
        .enable(enable_reg[pcwin_pkg::BIT_IO_WIN1_EN]),
        .start_addr(win1_start),
        .end_addr(win1_end),
        .addr(io_addr),
        .hit(hit1)
    );

    wire sel_win1 = !hit0 && hit1;
    wire any_hit = hit0 || hit1;
    wire [3:0] win_ctrl = sel_win1 ? ctrl[7:4] : ctrl[3:0];
    wire win1_width_from_card = ctrl[pcwin_pkg::WIN1_BASE + pcwin_pkg::BIT_WIDTH_FROM_CARD];
    wire win0_width_from_card = ctrl[pcwin_pkg::BIT_WIDTH_FROM_CARD];
    // Card source overrides the select bit
    wire sel_wide = win_ctrl[pcwin_pkg::BIT_WIDTH_FROM_CARD] ? card_wide
        : win_ctrl[pcwin_pkg::BIT_WIDTH_SELECT];
    wire [3:0] len_wide = win_ctrl[pcwin_pkg::BIT_WIDE_EXTRA_WAIT] ? pcwin_pkg::LEN_WAIT16
        : pcwin_pkg::LEN_STD16;
    wire [3:0] len_narrow = win_ctrl[pcwin_pkg::BIT_NARROW_FAST] ? pcwin_pkg::LEN_FAST8
        : pcwin_pkg::LEN_STD8;
    wire [3:0] sel_len = sel_wide ? len_wide : len_narrow;

    ////////////////////////////////////////////////////////////////////////////
    // ISA cycle enable and card cycle sequencer
    logic [2:0] div_cnt;
    wire isa_tick = (div_cnt == pcwin_pkg::ISA_DIV_LAST);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt <= 3'h0;
        else
            div_cnt <= isa_tick ? 3'h0 : div_cnt + 3'h1;
    end

    pcwin_pkg::pcwin_state_t state;
    logic [3:0] left;
    // Requests while busy are ignored; the host must wait for io_done
    wire start = (state == pcwin_pkg::ST_IDLE) && io_req && any_hit;
    wire finish = (state == pcwin_pkg::ST_RUN) && isa_tick && (left == 4'h1);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= pcwin_pkg::ST_IDLE;
            left <= 4'h0;
            io_claim <= 1'b0;
            io_win <= 1'b0;
            io_wide <= 1'b0;
            io_len <= 4'h0;
            io_done <= 1'b0;
        end
        else
        begin
            io_claim <= start;
            io_done <= finish;
            case (state)
                pcwin_pkg::ST_IDLE:
                    if (start)
                    begin
                        state <= pcwin_pkg::ST_RUN;
                        left <= sel_len;
                        io_win <= sel_win1;
                        io_wide <= sel_wide;
                        io_len <= sel_len;
                    end
                pcwin_pkg::ST_RUN:
                    if (isa_tick)
                    begin
                        left <= left - 4'h1;
                        if (left == 4'h1)
                            state <= pcwin_pkg::ST_IDLE;
                    end
                default: state <= pcwin_pkg::ST_IDLE;
            endcase
        end
    end
    assign io_busy = (state == pcwin_pkg::ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire st1 = start && sel_win1;
    wire st0 = start && !sel_win1;

    win1_wait_a: assert property (st1 && sel_wide && ctrl[7] |=> io_len == 4'h4)
        else $error("window 1 wide cycle not lengthened");
    win1_fast_a: assert property (st1 && !sel_wide && ctrl[6] |=> io_len == 4'h3)
        else $error("window 1 narrow cycle not shortened");
    win1_src_a: assert property (st1 && win1_width_from_card |=> io_wide == $past(card_wide))
        else $error("window 1 width not from card");
    win1_size_a: assert property (st1 && !ctrl[5] |=> io_wide == $past(ctrl[4]))
        else $error("window 1 width not from select bit");
    win0_wait_a: assert property (st0 && sel_wide && !ctrl[3] |=> io_len == 4'h3)
        else $error("window 0 wide cycle length wrong");
    win0_fast_a: assert property (st0 && !sel_wide && !ctrl[2] |=> io_len == 4'h6)
        else $error("window 0 narrow standard length wrong");
    win0_src_a: assert property (st0 && win0_width_from_card |=> io_wide == $past(card_wide))
        else $error("window 0 width not from card");
    win0_size_a: assert property (st0 && !ctrl[1] |=> io_wide == $past(ctrl[0]))
        else $error("window 0 width not from select bit");
    // Exactly one gap cycle between write and read, and it must not rewrite control
    ctrl_write_a: assert property (reg_wr && reg_addr == 8'h07
        ##1 !(reg_wr && reg_addr == 8'h07) ##1 reg_rd && reg_addr == 8'h07
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("control register readback wrong");
    start_low_a: assert property (reg_wr && reg_addr == 8'h0c |=> win1_start[7:0] == $past(reg_wdata))
        else $error("window 1 start low byte not stored");
    end_high_a: assert property (reg_wr && reg_addr == 8'h0b |=> win0_end[15:8] == $past(reg_wdata))
        else $error("window 0 end high byte not stored");
    no_claim_a: assert property (io_req && !io_busy && !enable_reg[7] && !enable_reg[6] |=> !io_claim)
        else $error("disabled window claimed a cycle");
    range_hit_a: assert property (io_req && !io_busy && enable_reg[6]
        && io_addr >= win0_start && io_addr <= win0_end |=> io_claim && !io_win)
        else $error("enabled window 0 hit not claimed");
    cycle_end_a: assert property (io_claim |-> io_busy ##[1:40] io_done)
        else $error("card cycle did not end");

    wide_wait_c: cover property (st1 && sel_wide && ctrl[7] ##[1:40] io_done);
    narrow_fast_c: cover property (st0 && !sel_wide && ctrl[2] ##[1:40] io_done);
    both_hit_c: cover property (start && hit0 && hit1);
endmodule // pcwin_cfg
`default_nettype wire

//--- pcwin_card.sv
// Behavioural 16-bit card: drives its width pin from its own port decode
`timescale 1ns/10ps
`default_nettype none
module pcwin_card #(
    parameter logic [15:0] WIDE_LO = 16'h01c0,
    parameter logic [15:0] WIDE_HI = 16'h027f
) (
    // Host address as seen on the socket
    input wire logic [15:0] io_addr,
    // Width pin
    output logic card_iois16
);
    // Pure decode, so the pin settles only after the address is stable
    assign card_iois16 = (io_addr >= WIDE_LO) && (io_addr <= WIDE_HI);
endmodule // pcwin_card
`default_nettype wire

//--- pcwin_cfg_tb.sv
// Self-checking bench for the I/O window configuration block
`timescale 1ns/10ps
`default_nettype none
module pcwin_cfg_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic io_req = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_claim, io_win, io_wide, io_busy, io_done, card_iois16;
    logic [3:0] io_len;
    int bad_count = 0;
    int checks = 0;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pcwin_reg_row_t;
    typedef struct {logic [7:0] c; logic [15:0] a; logic w; logic wd; logic [3:0] n;} pcwin_io_row_t;
    pcwin_reg_row_t regs [12] = '{
        '{8'h07, 8'ha5, 8'ha5}, '{8'h08, 8'h3c, 8'h3c}, '{8'h09, 8'hc3, 8'hc3},
        '{8'h0a, 8'h5a, 8'h5a}, '{8'h0b, 8'h96, 8'h96}, '{8'h0c, 8'h69, 8'h69},
        '{8'h0d, 8'hf0, 8'hf0}, '{8'h0e, 8'h0f, 8'h0f}, '{8'h0f, 8'h81, 8'h81},
        '{8'h06, 8'hff, 8'hdf}, '{8'h05, 8'hff, 8'h00}, '{8'h10, 8'hff, 8'h00}};
    // Window 0 0100-01ff, window 1 0180-02ff, card wide 01c0-027f
    logic [15:0] setup [9] = '{16'h0800, 16'h0901, 16'h0aff, 16'h0b01,
        16'h0c80, 16'h0d01, 16'h0eff, 16'h0f02, 16'h06c0};
    pcwin_io_row_t rows [15] = '{
        '{8'h00, 16'h0100, 1'b0, 1'b0, 4'h6},
        '{8'h01, 16'h01ff, 1'b0, 1'b1, 4'h3},
        '{8'h09, 16'h0150, 1'b0, 1'b1, 4'h4},
        '{8'h05, 16'h0150, 1'b0, 1'b1, 4'h3},
        '{8'h0c, 16'h0150, 1'b0, 1'b0, 4'h3},
        '{8'h0b, 16'h0150, 1'b0, 1'b0, 4'h6},
        '{8'h02, 16'h01d0, 1'b0, 1'b1, 4'h3},
        '{8'h10, 16'h0200, 1'b1, 1'b1, 4'h3},
        '{8'h90, 16'h0250, 1'b1, 1'b1, 4'h4},
        '{8'h40, 16'h0250, 1'b1, 1'b0, 4'h3},
        '{8'hc0, 16'h0250, 1'b1, 1'b0, 4'h3},
        '{8'h60, 16'h0250, 1'b1, 1'b1, 4'h3},
        '{8'h30, 16'h0280, 1'b1, 1'b0, 4'h6},
        '{8'h10, 16'h0190, 1'b0, 1'b0, 4'h6},
        '{8'h00, 16'h02ff, 1'b1, 1'b0, 4'h6}};
    ////////////////////////////////////////////////////////////////////////
    pcwin_cfg u_pcwin_cfg (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .io_req(io_req), .io_addr(io_addr), .io_claim(io_claim), .io_win(io_win),
        .io_wide(io_wide), .io_len(io_len), .io_busy(io_busy), .io_done(io_done),
        .card_iois16(card_iois16));
    pcwin_card u_pcwin_card (.io_addr(io_addr), .card_iois16(card_iois16));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    // Address leads the request so the synchronised card pin has settled
    task automatic io(input logic [15:0] a, input logic c, input logic w, input logic wd,
        input logic [3:0] n);
        int k;
        @(posedge clk);
        #1 io_addr = a;
        repeat (6) @(posedge clk);
        #1 io_req = 1'b1;
        @(posedge clk);
        #1 io_req = 1'b0;
        chk("io_claim", {15'h0000, c}, {15'h0000, io_claim});
        if (c)
        begin
            chk("io_win", {15'h0000, w}, {15'h0000, io_win});
            chk("io_wide", {15'h0000, wd}, {15'h0000, io_wide});
            chk("io_len", {12'h000, n}, {12'h000, io_len});
            chk("io_busy", 16'h0001, {15'h0000, io_busy});
            k = 0;
            while (io_done !== 1'b1 && k < 40)
            begin
                @(posedge clk);
                #1 k++;
            end
            if (k >= 40)
            begin
                bad_count++;
                complete_run();
            end
            else
            begin
                chk("cycle_time", 16'h0001, {15'h0000, (k > 5 * (n - 1)) && (k <= 5 * n)});
                chk("io_busy", 16'h0000, {15'h0000, io_busy});
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("io_busy", 16'h0000, {15'h0000, io_busy});
        for (int i = 6; i < 16; i++)
            rd(8'(i), 8'h00);
        $display("test reset done");
        foreach (regs[i])
        begin
            wr(regs[i].a, regs[i].d);
            rd(regs[i].a, regs[i].e);
        end
        $display("test registers done");
        foreach (setup[i])
            wr(setup[i][15:8], setup[i][7:0]);
        foreach (rows[i])
        begin
            wr(8'h07, rows[i].c);
            io(rows[i].a, 1'b1, rows[i].w, rows[i].wd, rows[i].n);
        end
        $display("test window timing done");
        io(16'h00ff, 1'b0, 1'b0, 1'b0, 4'h0);
        io(16'h0300, 1'b0, 1'b0, 1'b0, 4'h0);
        wr(8'h06, 8'h80);
        wr(8'h07, 8'h00);
        io(16'h0150, 1'b0, 1'b0, 1'b0, 4'h0);
        io(16'h0190, 1'b1, 1'b1, 1'b0, 4'h6);
        wr(8'h06, 8'h00);
        io(16'h0250, 1'b0, 1'b0, 1'b0, 4'h0);
        $display("test enables done");
        // Mid-run reset must clear the programmed windows again
        @(posedge clk);
        #1 rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 6; i < 16; i++)
            rd(8'(i), 8'h00);
        io(16'h0150, 1'b0, 1'b0, 1'b0, 4'h0);
        $display("test second reset done");
        complete_run();
    end
endmodule // pcwin_cfg_tb
`default_nettype wire
